/* File: core/basic_timer_pkg.sv */
// constants for the basic timer slave-mode controller
package basic_timer_pkg;

	// ==========================================================
	// register byte addresses
	localparam logic [7:0] SLAVE_MODE_CONTROL_ADDR = 8'h08;
	localparam logic [7:0] IRQ_DMA_ENABLE_ADDR     = 8'h0c;
	localparam logic [7:0] TIMER_STATUS_ADDR       = 8'h10;
	localparam logic [7:0] EVENT_STATUS_ADDR       = 8'h30;
	localparam logic [7:0] EVENT_CLEAR_ADDR        = 8'h34;
	localparam logic [7:0] EVENT_ENABLE_ADDR       = 8'h38;

	// ==========================================================
	// slave_mode_control fields
	localparam int GATE_MODE_ON_BIT         = 23;
	localparam int GATE_POLARITY_INVERT_BIT = 22;
	localparam int GATE_SOURCE_LSB          = 20;
	localparam int SLAVE_BEHAVIOUR_LSB      = 16;
	localparam int SYNC_DELAY_MASTER_BIT    = 7;
	localparam int SYNC_SOURCE_LSB          = 4;

	// ==========================================================
	// irq_dma_enable and timer_status fields
	localparam int UPDATE_DMA_ENABLE_BIT = 8;
	localparam int UPDATE_IRQ_ENABLE_BIT = 0;
	localparam int UPDATE_FLAG_BIT       = 0;

	// ==========================================================
	// event status bits
	localparam int EVENT_WIDTH      = 2;
	localparam int EVENT_UPDATE_BIT = 0;
	localparam int EVENT_TRIG_BIT   = 1;

	// ==========================================================
	// slave behaviour codes
	localparam logic [2:0] SLAVE_OFF       = 3'h0;
	localparam logic [2:0] SLAVE_RESET     = 3'h1;
	localparam logic [2:0] SLAVE_TRIGGER   = 3'h2;
	localparam logic [2:0] SLAVE_COMBINED  = 3'h3;
	localparam logic [2:0] SLAVE_EXT_CLOCK = 3'h4;

	// ==========================================================
	// reset values
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [2:0]  SEL3_ZERO = 3'h0;
	localparam logic [1:0]  SEL2_ZERO = 2'h0;

endpackage

/* File: core/basic_timer_slave_control.sv */
// slave-mode controller and update irq/dma enables of a basic timer
//
// Functional notes
// - in gated mode the counter advances only while the gate trigger is active
// - gate inactive stops counter, value kept; counting resumes when active again
// - gated mode and slave mode work together with separate trigger selections
// - gate polarity bit clear means active high, set means active low
// - gate source code 00..11 picks internal trigger zero..three
// - slave code 000 ignores the sync trigger
// - slave code 001: rising edge reinitialises counter and requests update
// - slave code 010: rising edge starts counter without reset
// - slave code 011: rising edge reinitialises, updates and starts counter
// - slave code 100: each rising edge gives one counter tick
// - active trigger edge is always the rising edge of the selected input
// - master/slave bit delays trigger effect so master and slaves align
// - sync source code 00..11 picks internal trigger zero..three
// - update dma request only while update dma enable is set
// - update interrupt only while update interrupt enable is set; event enable bit 0 also lets an update event raise irq
// - update flag set on each update event, cleared by writing zero
// - trigger mode sets counter run by hardware; gating needs run set
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module basic_timer_slave_control #(
	parameter int TRIG_COUNT = 4
) (
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic [7:0]              paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	output var  logic                    pready,
	output var  logic [31:0]             prdata,
	output var  logic                    pslverr,
	// internal triggers from other timers
	input  wire logic                    internal_trigger_zero,
	input  wire logic                    internal_trigger_one,
	input  wire logic                    internal_trigger_two,
	input  wire logic                    internal_trigger_three,
	// counter core
	input  wire logic                    counter_run,
	input  wire logic                    update_event,
	output var  logic                    counter_enable,
	output var  logic                    counter_tick,
	output var  logic                    counter_reinit,
	output var  logic                    update_request,
	output var  logic                    counter_run_set,
	// requests
	output var  logic                    update_dma_req,
	output var  logic                    irq
);
	import basic_timer_pkg::*;

	// ==========================================================
	// trigger synchronisers
	logic [TRIG_COUNT-1:0] trig_in;
	logic [TRIG_COUNT-1:0] trig_meta_r;
	logic [TRIG_COUNT-1:0] trig_sync_r;
	logic [TRIG_COUNT-1:0] trig_meta_nxt;
	logic [TRIG_COUNT-1:0] trig_sync_nxt;

	assign trig_in = {internal_trigger_three, internal_trigger_two,
		internal_trigger_one, internal_trigger_zero};

	// triggers may come from timers on other clocks, so always two stages
	always_comb begin
		trig_meta_nxt = trig_in;
		trig_sync_nxt = trig_meta_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_meta_r <= '0;
			trig_sync_r <= '0;
		end else begin
			trig_meta_r <= trig_meta_nxt;
			trig_sync_r <= trig_sync_nxt;
		end
	end

	// ==========================================================
	// configuration registers
	logic       gate_mode_on_r;
	logic       gate_polarity_invert_r;
	logic [1:0] gate_source_select_r;
	logic [2:0] slave_behaviour_select_r;
	logic       sync_delay_master_r;
	logic [1:0] sync_source_select_r;
	logic       update_dma_enable_r;
	logic       update_irq_enable_r;
	logic       update_flag_r;
	logic [EVENT_WIDTH-1:0] event_status_r;
	logic [EVENT_WIDTH-1:0] event_enable_r;

	logic       gate_mode_on_nxt;
	logic       gate_polarity_invert_nxt;
	logic [1:0] gate_source_select_nxt;
	logic [2:0] slave_behaviour_select_nxt;
	logic       sync_delay_master_nxt;
	logic [1:0] sync_source_select_nxt;
	logic       update_dma_enable_nxt;
	logic       update_irq_enable_nxt;
	logic       update_flag_nxt;
	logic [EVENT_WIDTH-1:0] event_status_nxt;
	logic [EVENT_WIDTH-1:0] event_enable_nxt;

	// ==========================================================
	// apb handshake
	logic        pready_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic        pready_nxt;
	logic [31:0] prdata_nxt;
	logic        pslverr_nxt;
	logic        setup;
	logic        wr_commit;
	logic        addr_hit;
	logic [31:0] read_word;

	// one wait-free access phase: answer is prepared during the setup cycle
	assign setup     = psel && !penable && !pready_r;
	assign wr_commit = psel && penable && pready_r && pwrite;

	function automatic logic decode_hit(input logic [7:0] a);
		decode_hit = (a == SLAVE_MODE_CONTROL_ADDR) || (a == IRQ_DMA_ENABLE_ADDR)
			|| (a == TIMER_STATUS_ADDR) || (a == EVENT_STATUS_ADDR)
			|| (a == EVENT_CLEAR_ADDR) || (a == EVENT_ENABLE_ADDR);
	endfunction

	assign addr_hit = decode_hit(paddr);

	always_comb begin
		read_word = WORD_ZERO;
		unique case (paddr)
			SLAVE_MODE_CONTROL_ADDR: begin
				read_word[GATE_MODE_ON_BIT]         = gate_mode_on_r;
				read_word[GATE_POLARITY_INVERT_BIT] = gate_polarity_invert_r;
				read_word[GATE_SOURCE_LSB+:2]       = gate_source_select_r;
				read_word[SLAVE_BEHAVIOUR_LSB+:3]   = slave_behaviour_select_r;
				read_word[SYNC_DELAY_MASTER_BIT]    = sync_delay_master_r;
				read_word[SYNC_SOURCE_LSB+:2]       = sync_source_select_r;
			end
			IRQ_DMA_ENABLE_ADDR: begin
				read_word[UPDATE_DMA_ENABLE_BIT] = update_dma_enable_r;
				read_word[UPDATE_IRQ_ENABLE_BIT] = update_irq_enable_r;
			end
			TIMER_STATUS_ADDR: begin
				read_word[UPDATE_FLAG_BIT] = update_flag_r;
			end
			EVENT_STATUS_ADDR: begin
				read_word[EVENT_WIDTH-1:0] = event_status_r;
			end
			EVENT_ENABLE_ADDR: begin
				read_word[EVENT_WIDTH-1:0] = event_enable_r;
			end
			default: read_word = WORD_ZERO;
		endcase
	end

	always_comb begin
		pready_nxt  = setup;
		prdata_nxt  = prdata_r;
		pslverr_nxt = 1'b0;
		if (setup) begin
			prdata_nxt  = (pwrite || !addr_hit) ? WORD_ZERO : read_word;
			pslverr_nxt = !addr_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			prdata_r  <= WORD_ZERO;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= pready_nxt;
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign pready  = pready_r;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

	// ==========================================================
	// trigger selection, edge detection and master delay
	logic       sync_level;
	logic       gate_level;
	logic       gate_active;
	logic       sync_prev_r;
	logic       sync_prev_nxt;
	logic       sync_edge;
	logic       slave_on;
	logic       edge_dly_r;
	logic       gate_dly_r;
	logic       edge_dly_nxt;
	logic       gate_dly_nxt;
	logic       edge_eff;
	logic       gate_eff;

	function automatic logic pick(input logic [TRIG_COUNT-1:0] v, input logic [1:0] s);
		pick = v[s];
	endfunction

	assign sync_level  = pick(trig_sync_r, sync_source_select_r);
	assign gate_level  = pick(trig_sync_r, gate_source_select_r);
	assign gate_active = gate_level ^ gate_polarity_invert_r;
	// internal triggers carry no polarity of their own: rising edge is active
	assign sync_edge   = sync_level && !sync_prev_r;
	// a change of source select may look like one edge; software should
	// select the source before picking a slave behaviour

	always_comb begin
		sync_prev_nxt = sync_level;
		edge_dly_nxt  = sync_edge;
		gate_dly_nxt  = gate_active;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_prev_r <= 1'b0;
			edge_dly_r  <= 1'b0;
			gate_dly_r  <= 1'b0;
		end else begin
			sync_prev_r <= sync_prev_nxt;
			edge_dly_r  <= edge_dly_nxt;
			gate_dly_r  <= gate_dly_nxt;
		end
	end

	// one extra cycle lets the master's trigger output reach its slaves
	assign edge_eff = sync_delay_master_r ? edge_dly_r : sync_edge;
	assign gate_eff = sync_delay_master_r ? gate_dly_r : gate_active;
	assign slave_on = edge_eff && (slave_behaviour_select_r != SLAVE_OFF);

	// ==========================================================
	// counter control outputs
	logic counter_enable_r;
	logic counter_tick_r;
	logic counter_reinit_r;
	logic update_request_r;
	logic counter_run_set_r;
	logic counter_enable_nxt;
	logic counter_tick_nxt;
	logic counter_reinit_nxt;
	logic update_request_nxt;
	logic counter_run_set_nxt;

	always_comb begin
		counter_tick_nxt    = 1'b0;
		counter_reinit_nxt  = 1'b0;
		update_request_nxt  = 1'b0;
		counter_run_set_nxt = 1'b0;
		// gating only qualifies a run bit that software already set
		counter_enable_nxt  = counter_run && (!gate_mode_on_r || gate_eff);
		if (slave_on) begin
			unique case (slave_behaviour_select_r)
				SLAVE_RESET: begin
					counter_reinit_nxt = 1'b1;
					update_request_nxt = 1'b1;
				end
				SLAVE_TRIGGER: begin
					counter_run_set_nxt = 1'b1;
				end
				SLAVE_COMBINED: begin
					counter_reinit_nxt  = 1'b1;
					update_request_nxt  = 1'b1;
					counter_run_set_nxt = 1'b1;
				end
				SLAVE_EXT_CLOCK: begin
					counter_tick_nxt = 1'b1;
				end
				default: counter_tick_nxt = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_enable_r  <= 1'b0;
			counter_tick_r    <= 1'b0;
			counter_reinit_r  <= 1'b0;
			update_request_r  <= 1'b0;
			counter_run_set_r <= 1'b0;
		end else begin
			counter_enable_r  <= counter_enable_nxt;
			counter_tick_r    <= counter_tick_nxt;
			counter_reinit_r  <= counter_reinit_nxt;
			update_request_r  <= update_request_nxt;
			counter_run_set_r <= counter_run_set_nxt;
		end
	end

	assign counter_enable  = counter_enable_r;
	assign counter_tick    = counter_tick_r;
	assign counter_reinit  = counter_reinit_r;
	assign update_request  = update_request_r;
	assign counter_run_set = counter_run_set_r;

	// ==========================================================
	// register writes, flags and requests
	logic                   update_dma_req_r;
	logic                   irq_r;
	logic                   update_dma_req_nxt;
	logic                   irq_nxt;
	logic [EVENT_WIDTH-1:0] event_set;
	logic [EVENT_WIDTH-1:0] event_clr;

	always_comb begin
		gate_mode_on_nxt           = gate_mode_on_r;
		gate_polarity_invert_nxt   = gate_polarity_invert_r;
		gate_source_select_nxt     = gate_source_select_r;
		slave_behaviour_select_nxt = slave_behaviour_select_r;
		sync_delay_master_nxt      = sync_delay_master_r;
		sync_source_select_nxt     = sync_source_select_r;
		update_dma_enable_nxt      = update_dma_enable_r;
		update_irq_enable_nxt      = update_irq_enable_r;
		event_enable_nxt           = event_enable_r;
		event_clr                  = '0;
		update_flag_nxt            = update_flag_r;
		if (wr_commit && (paddr == SLAVE_MODE_CONTROL_ADDR)) begin
			gate_mode_on_nxt           = pwdata[GATE_MODE_ON_BIT];
			gate_polarity_invert_nxt   = pwdata[GATE_POLARITY_INVERT_BIT];
			gate_source_select_nxt     = pwdata[GATE_SOURCE_LSB+:2];
			slave_behaviour_select_nxt = pwdata[SLAVE_BEHAVIOUR_LSB+:3];
			sync_delay_master_nxt      = pwdata[SYNC_DELAY_MASTER_BIT];
			sync_source_select_nxt     = pwdata[SYNC_SOURCE_LSB+:2];
		end
		if (wr_commit && (paddr == IRQ_DMA_ENABLE_ADDR)) begin
			update_dma_enable_nxt = pwdata[UPDATE_DMA_ENABLE_BIT];
			update_irq_enable_nxt = pwdata[UPDATE_IRQ_ENABLE_BIT];
		end
		if (wr_commit && (paddr == EVENT_ENABLE_ADDR)) begin
			event_enable_nxt = pwdata[EVENT_WIDTH-1:0];
		end
		if (wr_commit && (paddr == EVENT_CLEAR_ADDR)) begin
			event_clr = pwdata[EVENT_WIDTH-1:0];
		end
		// writing zero clears; a same-cycle update event wins
		if (wr_commit && (paddr == TIMER_STATUS_ADDR) && !pwdata[UPDATE_FLAG_BIT]) begin
			update_flag_nxt = 1'b0;
		end
		if (update_event) begin
			update_flag_nxt = 1'b1;
		end
		event_set                   = '0;
		event_set[EVENT_UPDATE_BIT] = update_event;
		event_set[EVENT_TRIG_BIT]   = slave_on;
		event_status_nxt            = (event_status_r & ~event_clr) | event_set;
		update_dma_req_nxt          = update_event && update_dma_enable_r;
		irq_nxt = (update_flag_nxt && update_irq_enable_nxt)
			|| |(event_status_nxt & event_enable_nxt);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_mode_on_r           <= 1'b0;
			gate_polarity_invert_r   <= 1'b0;
			gate_source_select_r     <= SEL2_ZERO;
			slave_behaviour_select_r <= SEL3_ZERO;
			sync_delay_master_r      <= 1'b0;
			sync_source_select_r     <= SEL2_ZERO;
			update_dma_enable_r      <= 1'b0;
			update_irq_enable_r      <= 1'b0;
			update_flag_r            <= 1'b0;
			event_status_r           <= '0;
			event_enable_r           <= '0;
			update_dma_req_r         <= 1'b0;
			irq_r                    <= 1'b0;
		end else begin
			gate_mode_on_r           <= gate_mode_on_nxt;
			gate_polarity_invert_r   <= gate_polarity_invert_nxt;
			gate_source_select_r     <= gate_source_select_nxt;
			slave_behaviour_select_r <= slave_behaviour_select_nxt;
			sync_delay_master_r      <= sync_delay_master_nxt;
			sync_source_select_r     <= sync_source_select_nxt;
			update_dma_enable_r      <= update_dma_enable_nxt;
			update_irq_enable_r      <= update_irq_enable_nxt;
			update_flag_r            <= update_flag_nxt;
			event_status_r           <= event_status_nxt;
			event_enable_r           <= event_enable_nxt;
			update_dma_req_r         <= update_dma_req_nxt;
			irq_r                    <= irq_nxt;
		end
	end

	assign update_dma_req = update_dma_req_r;
	assign irq            = irq_r;

endmodule

`default_nettype wire

/* File: verif/basic_timer_slave_control_properties.sv */
// port-level assertions for the slave-mode controller
`timescale 1ns/1ns
`default_nettype none
module basic_timer_slave_control_properties #(
	parameter int TRIG_COUNT = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// counter core
	input wire logic counter_run,
	input wire logic update_event,
	input wire logic counter_enable,
	input wire logic counter_tick,
	input wire logic counter_reinit,
	input wire logic update_request,
	input wire logic update_dma_req,
	input wire logic irq
);
	// =====
	// clocking
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// =====
	// bus
	pready_timing_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// =====
	// counter control
	dma_cause_a: assert property (update_dma_req |-> $past(update_event))
		else $error("dma request without update");
	reinit_pair_a: assert property ((counter_reinit || update_request) |->
		(counter_reinit && update_request))
		else $error("reinit and update split");
	// trigger edges are at least four cycles apart
	tick_single_a: assert property (counter_tick |=> !counter_tick [*3])
		else $error("tick not a single pulse");
	enable_run_a: assert property ((!counter_run) [*4] |-> !counter_enable)
		else $error("enable without run bit");
	reset_quiet_a: assert property ($rose(presetn) |-> !irq && !pready && !counter_enable)
		else $error("outputs active after reset");
endmodule
bind basic_timer_slave_control basic_timer_slave_control_properties #(
	.TRIG_COUNT(TRIG_COUNT)
) chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .counter_run(counter_run), .update_event(update_event),
	.counter_enable(counter_enable), .counter_tick(counter_tick),
	.counter_reinit(counter_reinit), .update_request(update_request),
	.update_dma_req(update_dma_req), .irq(irq)
);
`default_nettype wire

/* File: verif/trigger_source_model.sv */
// model of the neighbouring timers that drive the internal triggers
`timescale 1ns/1ns
`default_nettype none
module trigger_source_model (
	// clock
	input  wire logic       pclk,
	// trigger levels
	output var  logic [3:0] trig
);
	initial trig = 4'h0;
	task automatic set_lvl(input int idx, input logic lvl);
		@(posedge pclk);
		trig[idx] <= lvl;
	endtask
	// levels held four cycles: shorter ones may slip past the synchroniser
	task automatic pulse(input int idx);
		set_lvl(idx, 1'b1);
		repeat (3) @(posedge pclk);
		set_lvl(idx, 1'b0);
		repeat (3) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

/* File: verif/basic_timer_slave_control_tb.sv */
// self-checking bench for the slave-mode controller
`timescale 1ns/1ns
`default_nettype none
module basic_timer_slave_control_tb;
	import basic_timer_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  trig;
	logic        counter_run, update_event, counter_enable, counter_tick;
	logic        counter_reinit, update_request, counter_run_set, update_dma_req, irq;
	int          miscompares, n_checks, n_reinit, n_upd, n_tick, n_run;
	// =====
	// instances
	trigger_source_model src (.pclk(pclk), .trig(trig));
	basic_timer_slave_control dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .internal_trigger_zero(trig[0]),
		.internal_trigger_one(trig[1]), .internal_trigger_two(trig[2]),
		.internal_trigger_three(trig[3]), .counter_run(counter_run),
		.update_event(update_event), .counter_enable(counter_enable),
		.counter_tick(counter_tick), .counter_reinit(counter_reinit),
		.update_request(update_request), .counter_run_set(counter_run_set),
		.update_dma_req(update_dma_req), .irq(irq)
	);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		n_reinit += int'(counter_reinit === 1'b1);
		n_upd += int'(update_request === 1'b1);
		n_tick += int'(counter_tick === 1'b1);
		n_run += int'(counter_run_set === 1'b1);
	end
	// =====
	// helpers
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		check(what, exp, r);
	endtask
	function automatic logic [31:0] mode_word(input int gate_on, gate_inv, gate_src, behav,
		delay_on, sync_src);
		return 32'(gate_on) << GATE_MODE_ON_BIT | 32'(gate_inv) << GATE_POLARITY_INVERT_BIT
			| 32'(gate_src) << GATE_SOURCE_LSB | 32'(behav) << SLAVE_BEHAVIOUR_LSB
			| 32'(delay_on) << SYNC_DELAY_MASTER_BIT | 32'(sync_src) << SYNC_SOURCE_LSB;
	endfunction
	// =====
	// scenarios
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		rd("mode reset", SLAVE_MODE_CONTROL_ADDR, WORD_ZERO);
		rd("enable reset", IRQ_DMA_ENABLE_ADDR, WORD_ZERO);
		rd("status reset", TIMER_STATUS_ADDR, WORD_ZERO);
		wr(SLAVE_MODE_CONTROL_ADDR, 32'h00f7_00b0);
		rd("mode fields", SLAVE_MODE_CONTROL_ADDR, 32'h00f7_00b0);
		wr(IRQ_DMA_ENABLE_ADDR, 32'h0000_0101);
		rd("enable fields", IRQ_DMA_ENABLE_ADDR, 32'h0000_0101);
		wr(SLAVE_MODE_CONTROL_ADDR, WORD_ZERO);
		wr(IRQ_DMA_ENABLE_ADDR, WORD_ZERO);
		apb(1'b0, 8'hfc, 32'h0, r, e);
		check("unmapped error", 32'h1, 32'(e));
		check("unmapped data", WORD_ZERO, r);
	endtask
	task automatic t_gate();
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 2; p++) begin
				wr(SLAVE_MODE_CONTROL_ADDR, mode_word(1, p, s, 0, 0, 0));
				src.set_lvl(s, !p[0]);
				repeat (6) @(posedge pclk);
				check("gate open", 32'h1, 32'(counter_enable));
				src.set_lvl(s, p[0]);
				repeat (6) @(posedge pclk);
				check("gate shut", 32'h0, 32'(counter_enable));
				src.set_lvl(s, 1'b0);
			end
		end
		// gate still open here, so only the run bit can hold the counter
		counter_run <= 1'b0;
		repeat (6) @(posedge pclk);
		check("gate without run", 32'h0, 32'(counter_enable));
		counter_run <= 1'b1;
	endtask
	task automatic t_slave();
		for (int c = 0; c < 8; c++) begin
			wr(SLAVE_MODE_CONTROL_ADDR, mode_word(1, 0, (c + 1) % 4, c, 0, c % 4));
			src.set_lvl((c + 1) % 4, 1'b1);
			repeat (6) @(posedge pclk);
			{n_reinit, n_upd, n_tick, n_run} = '0;
			src.pulse(c % 4);
			repeat (4) @(posedge pclk);
			check("reinit count", 32'(c == 1 || c == 3), 32'(n_reinit));
			check("update count", 32'(c == 1 || c == 3), 32'(n_upd));
			check("start count", 32'(c == 2 || c == 3), 32'(n_run));
			check("tick count", 32'(c == 4), 32'(n_tick));
			check("gate beside slave", 32'h1, 32'(counter_enable));
			src.set_lvl((c + 1) % 4, 1'b0);
			repeat (6) @(posedge pclk);
		end
	endtask
	task automatic t_delay();
		int lat [2];
		for (int m = 0; m < 2; m++) begin
			wr(SLAVE_MODE_CONTROL_ADDR, mode_word(0, 0, 0, 1, m, 2));
			src.set_lvl(2, 1'b1);
			lat[m] = 0;
			while (counter_reinit !== 1'b1 && lat[m] < 20) begin
				@(posedge pclk);
				lat[m]++;
			end
			src.set_lvl(2, 1'b0);
			repeat (4) @(posedge pclk);
		end
		check("master delay step", 32'h1, 32'(lat[1] - lat[0]));
	endtask
	task automatic ev(output logic d);
		@(posedge pclk);
		update_event <= 1'b1;
		@(posedge pclk);
		update_event <= 1'b0;
		@(posedge pclk);
		d = update_dma_req;
	endtask
	task automatic t_update();
		logic d;
		ev(d);
		check("dma masked", 32'h0, 32'(d));
		check("irq masked", 32'h0, 32'(irq));
		rd("flag set", TIMER_STATUS_ADDR, 32'h1);
		wr(IRQ_DMA_ENABLE_ADDR, 32'h1);
		@(posedge pclk);
		check("irq raised", 32'h1, 32'(irq));
		wr(TIMER_STATUS_ADDR, 32'h1);
		rd("flag kept", TIMER_STATUS_ADDR, 32'h1);
		wr(TIMER_STATUS_ADDR, WORD_ZERO);
		@(posedge pclk);
		check("irq dropped", 32'h0, 32'(irq));
		rd("flag cleared", TIMER_STATUS_ADDR, WORD_ZERO);
		wr(IRQ_DMA_ENABLE_ADDR, 32'h0000_0101);
		ev(d);
		check("dma request", 32'h1, 32'(d));
		check("irq on update", 32'h1, 32'(irq));
	endtask
	// both event bits are set by now: trigger actions earlier, update events just before
	task automatic t_events();
		logic d;
		rd("event status", EVENT_STATUS_ADDR, 32'h0000_0003);
		wr(EVENT_CLEAR_ADDR, 32'h0000_0003);
		rd("event cleared", EVENT_STATUS_ADDR, WORD_ZERO);
		wr(IRQ_DMA_ENABLE_ADDR, WORD_ZERO);
		wr(EVENT_ENABLE_ADDR, 32'h0000_0001);
		rd("event enable", EVENT_ENABLE_ADDR, 32'h0000_0001);
		ev(d);
		check("event irq", 32'h1, 32'(irq));
		wr(EVENT_CLEAR_ADDR, 32'h0000_0001);
		@(posedge pclk);
		check("event irq cleared", 32'h0, 32'(irq));
	endtask
	task automatic close_out();
		if (miscompares == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// =====
	// sequence
	initial begin
		{presetn, psel, penable, pwrite, counter_run, update_event} = '0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		counter_run <= 1'b1;
		t_gate();
		t_slave();
		t_delay();
		t_update();
		t_events();
		close_out();
	end
	initial begin
		#200000;
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire
